// file: hdl/ccu_pkg.sv
// Notes on behaviour
// RL1: the result uses only the fixed 32-bit polynomial 0x4C11DB7.
// RL2: folding takes four cycles for a word, two for a half-word, one for a byte.
// RL3: each new input folds into the stored result until a reload.
// RL4: a 32-bit buffer holds the input so the write completes without waits; the code stalls a result write accepted while the engine is still folding.
// RL5: the scratch byte reads back the last written value, unrelated to the result.
// RL6: control writes and reloads never change the scratch byte.
// RL7: control bits 6:5 select none, 8-bit, 16-bit or 32-bit input mirroring.
// RL8: input groups stay in place; only the bit order inside each is mirrored.
// RL9: control bit 7 set mirrors all 32 result bits on read.
// RL10: writing 1 to control bit 0 reloads the result from the initial value, self-clearing.
// RL11: the initial value is software programmable and resets to all ones.
// RL12: a result read returns the computed result, never the raw written data.
// RL13: software accesses every register as a whole 32-bit word, except the result, which also takes byte and half-word writes.
// RL14: inputs of mixed sizes may follow one another within one calculation.
// RL15: software writes reserved control and scratch bits only as zero.
// RL16: input size follows the write size; narrow writes use the low 8 or 16 bits; with mirroring wider than the write, the code takes higher bits.
// RL17: a result read during a calculation waits until the calculation finishes.
`default_nettype none
package ccu_pkg;
  localparam logic [31:0] CCU_POLY = 32'h04C1_1DB7;
  localparam logic [4:0] CCU_OFS_RESULT = 5'h00;
  localparam logic [4:0] CCU_OFS_SCRATCH = 5'h04;
  localparam logic [4:0] CCU_OFS_CONTROL = 5'h08;
  localparam logic [4:0] CCU_OFS_INIT = 5'h10;
  localparam logic [31:0] CCU_RST_RESULT = 32'hFFFF_FFFF;
  localparam logic [31:0] CCU_RST_INIT = 32'hFFFF_FFFF;
  localparam logic [7:0] CCU_RST_SCRATCH = 8'h00;
  localparam logic CCU_RST_OUT_MIRROR = 1'b0;
  localparam logic [1:0] CCU_RST_IN_SELECT = 2'h0;
  localparam int CCU_CTL_RELOAD_BIT = 0;
  localparam int CCU_CTL_INSEL_LSB = 5;
  localparam int CCU_CTL_OUTMIR_BIT = 7;
  localparam logic [2:0] CCU_CYC_BYTE = 3'h1;
  localparam logic [2:0] CCU_CYC_HALF = 3'h2;
  localparam logic [2:0] CCU_CYC_WORD = 3'h4;
  localparam logic [2:0] CCU_SZ_BYTE = 3'h0;
  localparam logic [2:0] CCU_SZ_HALF = 3'h1;

  typedef enum logic [1:0] {
    CCU_REV_NONE = 2'b00,
    CCU_REV_BYTE = 2'b01,
    CCU_REV_HALF = 2'b10,
    CCU_REV_WORD = 2'b11
  } ccu_insel_type;

  typedef struct packed {
    logic [4:0] addr;
    logic write;
    logic [2:0] size;
  } ccu_access_type;

  function automatic logic [31:0] ccu_mirror32(input logic [31:0] v);
    logic [31:0] r;
    r = '0;
    for (int i = 0; i < 32; i++) begin
      r[i] = v[31-i];
    end
    return r;
  endfunction

  // groups keep their place, bits inside each group mirrored
  function automatic logic [31:0] ccu_reverse_input(input logic [31:0] v, input logic [1:0] sel);
    logic [31:0] m;
    logic [31:0] r;
    m = ccu_mirror32(v);
    r = v;
    unique case (ccu_insel_type'(sel)) // [RL7] [RL8]
      CCU_REV_NONE: r = v;
      CCU_REV_BYTE: r = {m[7:0], m[15:8], m[23:16], m[31:24]};
      CCU_REV_HALF: r = {m[15:0], m[31:16]};
      CCU_REV_WORD: r = m;
    endcase
    return r;
  endfunction
endpackage : ccu_pkg
`default_nettype wire

// file: hdl/ccu_byte_fold.sv
`default_nettype none
module ccu_byte_fold
  import ccu_pkg::*;
(
  input wire logic [31:0] i_crc,
  input wire logic [7:0] i_byte,
  output logic [31:0] o_crc
);
  always_comb begin
    logic [31:0] c;
    c = i_crc ^ {i_byte, 24'h00_0000};
    for (int i = 0; i < 8; i++) begin
      c = c[31] ? ((c << 1) ^ CCU_POLY) : (c << 1); // [RL1]
    end
    o_crc = c;
  end
endmodule : ccu_byte_fold
`default_nettype wire

// file: hdl/ccu_top.sv
`default_nettype none
module ccu_top
  import ccu_pkg::*;
#(
  parameter int ADDR_W = 32
) (
  input wire logic I_CLK_SYS,
  input wire logic I_RST_N,
  input wire logic I_HSEL,
  input wire logic [ADDR_W-1:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP
);
  if (ADDR_W < 5) begin : g_chk
    $error("ccu_top: ADDR_W must be at least 5");
  end

  logic [31:0] crc_q, crc_d;
  logic [31:0] init_q, init_d;
  logic [7:0] scratch_q, scratch_d;
  logic out_mirror_q, out_mirror_d;
  logic [1:0] in_select_q, in_select_d;
  logic [31:0] buf_q, buf_d;
  logic [2:0] count_q, count_d;
  ccu_access_type pend_q, pend_d;
  logic pend_vld_q, pend_vld_d;
  logic hready_q, hready_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic [31:0] fold_out;
  logic [31:0] din;
  logic [31:0] rd_val;
  logic [4:0] rd_addr;
  ccu_access_type acc_new;
  logic accept;
  logic data_done;
  logic wr_done;
  logic new_waits;

  ccu_byte_fold u_fold (
    .i_crc(crc_q),
    .i_byte(buf_q[31:24]),
    .o_crc(fold_out)
  );

  assign accept = I_HSEL & I_HTRANS[1] & I_HREADY;
  assign acc_new = '{addr: I_HADDR[4:0], write: I_HWRITE, size: I_HSIZE};
  assign data_done = pend_vld_q & hready_q;
  assign wr_done = data_done & pend_q.write;
  assign din = ccu_reverse_input(I_HWDATA, in_select_q); // [RL7]
  assign new_waits = (acc_new.addr == CCU_OFS_RESULT) | ((acc_new.addr == CCU_OFS_CONTROL) & acc_new.write);

  // register state and the fold engine
  always_comb begin
    crc_d = crc_q;
    init_d = init_q;
    scratch_d = scratch_q;
    out_mirror_d = out_mirror_q;
    in_select_d = in_select_q;
    buf_d = buf_q;
    count_d = count_q;
    if (count_q != 3'h0) begin
      crc_d = fold_out; // [RL3] [RL2]
      buf_d = {buf_q[23:0], 8'h00};
      count_d = count_q - 3'h1;
    end
    if (wr_done) begin
      unique case (pend_q.addr)
        CCU_OFS_RESULT: begin
          // any size may follow any other: [RL14]
          if (pend_q.size == CCU_SZ_BYTE) begin // [RL16]
            buf_d = {din[7:0], 24'h00_0000};
            count_d = CCU_CYC_BYTE;
          end else if (pend_q.size == CCU_SZ_HALF) begin
            buf_d = {din[15:0], 16'h0000};
            count_d = CCU_CYC_HALF;
          end else begin
            buf_d = din; // [RL4]
            count_d = CCU_CYC_WORD;
          end
        end
        CCU_OFS_SCRATCH: scratch_d = I_HWDATA[7:0]; // [RL5]
        CCU_OFS_CONTROL: begin
          out_mirror_d = I_HWDATA[CCU_CTL_OUTMIR_BIT];
          in_select_d = I_HWDATA[CCU_CTL_INSEL_LSB +: 2];
          if (I_HWDATA[CCU_CTL_RELOAD_BIT]) begin
            crc_d = init_q; // [RL10] [RL6]
          end
        end
        CCU_OFS_INIT: init_d = I_HWDATA; // [RL11]
        default: ;
      endcase
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      crc_q <= CCU_RST_RESULT;
      init_q <= CCU_RST_INIT;
      scratch_q <= CCU_RST_SCRATCH;
      out_mirror_q <= CCU_RST_OUT_MIRROR;
      in_select_q <= CCU_RST_IN_SELECT;
      buf_q <= 32'h0000_0000;
      count_q <= 3'h0;
    end else begin
      crc_q <= crc_d;
      init_q <= init_d;
      scratch_q <= scratch_d;
      out_mirror_q <= out_mirror_d;
      in_select_q <= in_select_d;
      buf_q <= buf_d;
      count_q <= count_d;
    end
  end

  // read value built from the next state so it shows the finished result
  always_comb begin
    rd_addr = accept ? acc_new.addr : pend_q.addr;
    unique case (rd_addr)
      CCU_OFS_RESULT: rd_val = out_mirror_d ? ccu_mirror32(crc_d) : crc_d; // [RL9] [RL12]
      CCU_OFS_SCRATCH: rd_val = {24'h00_0000, scratch_d};
      CCU_OFS_CONTROL: rd_val = {24'h00_0000, out_mirror_d, in_select_d, 5'h00};
      CCU_OFS_INIT: rd_val = init_d;
      default: rd_val = 32'h0000_0000;
    endcase
  end

  // bus slave: waits only while the engine is still folding
  always_comb begin
    pend_d = pend_q;
    pend_vld_d = pend_vld_q;
    hready_d = 1'b1;
    hrdata_d = hrdata_q;
    if (accept) begin
      pend_d = acc_new;
      pend_vld_d = 1'b1;
      hready_d = !(new_waits && (count_d != 3'h0)); // [RL17] [RL4]
      if (!acc_new.write) begin
        hrdata_d = rd_val;
      end
    end else begin
      if (data_done) begin
        pend_vld_d = 1'b0;
      end
      if (pend_vld_q && !hready_q) begin
        hready_d = (count_d == 3'h0); // [RL17]
        if (!pend_q.write) begin
          hrdata_d = rd_val;
        end
      end
    end
  end

  always_ff @(posedge I_CLK_SYS) begin
    if (!I_RST_N) begin
      pend_q <= '0;
      pend_vld_q <= 1'b0;
      hready_q <= 1'b1;
      hrdata_q <= 32'h0000_0000;
      O_HRESP <= 1'b0;
    end else begin
      pend_q <= pend_d;
      pend_vld_q <= pend_vld_d;
      hready_q <= hready_d;
      hrdata_q <= hrdata_d;
      O_HRESP <= 1'b0;
    end
  end

  assign O_HRDATA = hrdata_q;
  assign O_HREADYOUT = hready_q;

  reload_from_init_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // [RL10]
    wr_done && pend_q.addr == CCU_OFS_CONTROL && I_HWDATA[CCU_CTL_RELOAD_BIT]
    |=> crc_q == $past(init_q) && count_q == 3'h0)
    else $error("reload did not load the initial value");

  word_four_cycles_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // [RL2]
    wr_done && pend_q.addr == CCU_OFS_RESULT && pend_q.size[1]
    |=> count_q == 3'h4 ##4 count_q == 3'h0)
    else $error("word fold did not take four cycles");

  half_two_cycles_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // [RL2] [RL16]
    wr_done && pend_q.addr == CCU_OFS_RESULT && pend_q.size == CCU_SZ_HALF
    |=> count_q == 3'h2 ##1 count_q == 3'h1 ##1 count_q == 3'h0)
    else $error("half-word fold did not take two cycles");

  byte_one_cycle_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // [RL2] [RL16]
    wr_done && pend_q.addr == CCU_OFS_RESULT && pend_q.size == CCU_SZ_BYTE
    |=> count_q == 3'h1 ##1 count_q == 3'h0)
    else $error("byte fold did not take one cycle");

  fold_accumulates_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // [RL3] [RL1]
    count_q != 3'h0 |=> crc_q == $past(fold_out))
    else $error("fold step did not build on the stored result");

  scratch_holds_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // [RL5] [RL6]
    !(wr_done && pend_q.addr == CCU_OFS_SCRATCH) |=> $stable(scratch_q))
    else $error("scratch byte changed without a scratch write");

  idle_no_wait_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // [RL4]
    accept && count_q == 3'h0 && !data_done |=> hready_q)
    else $error("access to an idle unit was stalled");

  busy_read_held_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // [RL17]
    pend_vld_q && !pend_q.write && pend_q.addr == CCU_OFS_RESULT && count_q != 3'h0 |-> !hready_q)
    else $error("result read completed while folding");

  result_read_value_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // [RL12] [RL9]
    data_done && !pend_q.write && pend_q.addr == CCU_OFS_RESULT
    |-> O_HRDATA == (out_mirror_q ? ccu_mirror32(crc_q) : crc_q))
    else $error("result read did not return the computed result");

  scratch_write_lands_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // [RL5]
    wr_done && pend_q.addr == CCU_OFS_SCRATCH |=> scratch_q == $past(I_HWDATA[7:0]))
    else $error("scratch write did not land");

  init_write_lands_a: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // [RL11]
    wr_done && pend_q.addr == CCU_OFS_INIT |=> init_q == $past(I_HWDATA))
    else $error("initial value write did not land");
endmodule : ccu_top
`default_nettype wire

// file: verif/ccu_host_model.sv
`default_nettype none
module ccu_host_model
  import ccu_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_hready,
  input wire logic [31:0] i_hrdata,
  output logic o_hsel,
  output logic [31:0] o_haddr,
  output logic [1:0] o_htrans,
  output logic o_hwrite,
  output logic [2:0] o_hsize,
  output logic [31:0] o_hwdata
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_hsel = 1'b0;
    o_haddr = 32'h0000_0000;
    o_htrans = 2'h0;
    o_hwrite = 1'b0;
    o_hsize = 3'h2;
    o_hwdata = 32'h0000_0000;
  end
  // data phase: hold until ready seen high, bounded
  task automatic wait_ready(output int n, output logic [31:0] d);
    n = 0;
    while (!i_hready && n < 20) begin
      @(posedge i_clk);
      #1;
      n++;
    end
    d = i_hrdata;
    @(posedge i_clk);
    #1;
  endtask
  // chain puts a result read in the write's data phase
  task automatic xfer(input logic w, input logic [4:0] a, input logic [2:0] sz, input logic [31:0] wd,
                      input logic chain, output logic [31:0] rd, output int ww, output int rw);
    o_hsel = 1'b1;
    o_htrans = 2'h2;
    o_haddr = {27'h0, a};
    o_hwrite = w;
    o_hsize = sz;
    @(posedge i_clk);
    #1;
    o_hwdata = w ? wd : ~o_hwdata;
    o_hsel = chain;
    o_htrans = chain ? 2'h2 : 2'h0;
    o_haddr = 32'h0000_0000;
    o_hwrite = 1'b0;
    o_hsize = 3'h2;
    wait_ready(ww, rd);
    o_hwdata = ~o_hwdata;
    rw = 0;
    // select is already low unless chained, so the next call raises it only once
    if (chain) begin
      o_hsel = 1'b0;
      o_htrans = 2'h0;
      wait_ready(rw, rd);
    end
  endtask
endmodule // ccu_host_model
`default_nettype wire

// file: verif/ccu_top_tb_top.sv
`default_nettype none
module ccu_top_tb_top
  import ccu_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic hsel, hwrite, hready, hresp;
  logic [31:0] haddr, hwdata, hrdata, rd, exp_v, dw;
  logic [1:0] htrans;
  logic [2:0] hsize;
  int err_total = 0;
  int checks_done = 0;
  int ww, rw, rw_w, rw_h, rw_b;
  always #5 clk_sys = ~clk_sys;
  ccu_top dut_u (.I_CLK_SYS(clk_sys), .I_RST_N(rst_n), .I_HSEL(hsel), .I_HADDR(haddr), .I_HTRANS(htrans),
    .I_HWRITE(hwrite), .I_HSIZE(hsize), .I_HWDATA(hwdata), .I_HREADY(hready), .O_HRDATA(hrdata),
    .O_HREADYOUT(hready), .O_HRESP(hresp));
  ccu_host_model host_u (.i_clk(clk_sys), .i_hready(hready), .i_hrdata(hrdata), .o_hsel(hsel),
    .o_haddr(haddr), .o_htrans(htrans), .o_hwrite(hwrite), .o_hsize(hsize), .o_hwdata(hwdata));
  task automatic test_done();
    $display("comparisons %0d, mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] seen, input logic [31:0] e);
    checks_done++;
    if (seen !== e) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, e);
    end
  endtask
  task automatic acc(input logic w, input logic [4:0] a, input logic [2:0] sz, input logic [31:0] d, input logic c);
    host_u.xfer(w, a, sz, d, c, rd, ww, rw);
    if (ww >= 20 || rw >= 20) begin
      err_total++;
      $display("wrong value at %0t: bus wait ran out", $time);
      test_done();
    end
  endtask
  task automatic rdc(input logic [4:0] a, input logic [31:0] e);
    acc(1'b0, a, 3'h2, 32'h0000_0000, 1'b0);
    chk(rd, e);
    chk({31'h0, hresp}, 32'h0000_0000);
  endtask
  // mirror inside groups of g bits, groups stay in place
  function automatic logic [31:0] grev(input logic [31:0] v, input int g);
    logic [31:0] r;
    for (int i = 0; i < 32; i++) r[i] = v[(i / g) * g + g - 1 - i % g];
    return r;
  endfunction
  function automatic logic [31:0] fold(input logic [31:0] c, input logic [31:0] d, input int n);
    for (int i = n - 1; i >= 0; i--) c = {c[30:0], 1'b0} ^ ((c[31] ^ d[i]) ? CCU_POLY : 32'h0000_0000);
    return c;
  endfunction
  initial begin
    repeat (20) @(posedge clk_sys);
    #1 rst_n = 1'b1;
    rdc(CCU_OFS_RESULT, 32'hFFFF_FFFF);
    rdc(CCU_OFS_INIT, 32'hFFFF_FFFF);
    rdc(CCU_OFS_SCRATCH, 32'h0000_0000);
    rdc(CCU_OFS_CONTROL, 32'h0000_0000);
    rdc(5'h0C, 32'h0000_0000);
    $display("test reset values done");
    acc(1'b1, CCU_OFS_SCRATCH, 3'h2, 32'h0000_00A5, 1'b0);
    acc(1'b1, CCU_OFS_CONTROL, 3'h2, 32'h0000_0001, 1'b0);
    rdc(CCU_OFS_SCRATCH, 32'h0000_00A5);
    acc(1'b1, CCU_OFS_INIT, 3'h2, 32'h1234_5678, 1'b0);
    for (int s = 0; s < 4; s++) begin
      acc(1'b1, CCU_OFS_CONTROL, 3'h2, {25'h0, 2'(s), 5'h01}, 1'b0);
      rdc(CCU_OFS_CONTROL, {25'h0, 2'(s), 5'h00});
      exp_v = 32'h1234_5678;
      for (int k = 0; k < 2; k++) begin
        dw = 32'h3456_CDEF ^ (k << s);
        exp_v = fold(exp_v, grev(dw, s == 0 ? 1 : 4 << s), 32);
        acc(1'b1, CCU_OFS_RESULT, 3'h2, dw, 1'b1);
        chk(rd, exp_v);
        chk(32'(ww), 32'h0000_0000);
      end
    end
    acc(1'b1, CCU_OFS_CONTROL, 3'h2, 32'h0000_0080, 1'b0);
    rdc(CCU_OFS_RESULT, grev(exp_v, 32));
    $display("test modes done");
    acc(1'b1, CCU_OFS_CONTROL, 3'h2, 32'h0000_0001, 1'b0);
    exp_v = fold(fold(32'h1234_5678, 32'h3322_1100, 32), 32'h0000_5544, 16);
    acc(1'b1, CCU_OFS_RESULT, 3'h2, 32'h3322_1100, 1'b1);
    rw_w = rw;
    acc(1'b1, CCU_OFS_RESULT, 3'h1, 32'hABCD_5544, 1'b1);
    rw_h = rw;
    chk(rd, exp_v);
    acc(1'b1, CCU_OFS_CONTROL, 3'h2, 32'h0000_0001, 1'b0);
    acc(1'b1, CCU_OFS_RESULT, 3'h1, 32'h0000_3322, 1'b0);
    acc(1'b1, CCU_OFS_RESULT, 3'h1, 32'hFFFF_1100, 1'b0);
    acc(1'b1, CCU_OFS_RESULT, 3'h1, 32'h0000_5544, 1'b0);
    rdc(CCU_OFS_RESULT, exp_v);
    acc(1'b1, CCU_OFS_RESULT, 3'h0, 32'hFFFF_FF77, 1'b1);
    rw_b = rw;
    chk(rd, fold(exp_v, 32'h0000_0077, 8));
    chk(32'(rw_w - rw_h), 32'h0000_0002);
    chk(32'(rw_h - rw_b), 32'h0000_0001);
    rdc(CCU_OFS_SCRATCH, 32'h0000_00A5);
    $display("test mixed sizes done");
    test_done();
  end
endmodule // ccu_top_tb_top
`default_nettype wire
